/* src/ascl_top.sv */
// Summary of operation
// [RULE1] Without compare, every finished conversion sets the done flag, bit 7.
// [RULE2] With compare on, done is set only when the compare is true.
// [RULE3] Writing status/control or reading the result clears done.
// [RULE4] Done rising with interrupt enable bit 6 high sets status bit 0; irq follows only if enable bit 0 is also set.
// [RULE5] Single mode: one conversion per write or per hardware trigger.
// [RULE6] Continuous, software trigger: a write starts back-to-back conversions.
// [RULE7] Continuous, hardware trigger: a trigger starts back-to-back conversions.
// [RULE8] Channel codes: 0-27 inputs, 28 reserved, 29 high ref, 30 low ref.
// [RULE9] All-ones channel turns the converter off and isolates the input.
// [RULE10] Ending continuous mode by all-ones starts no extra conversion.
// [RULE11] Without continuous mode the core powers down after each conversion.
// [RULE12] Hardware trigger input, trigger-select bit and readable result register.
`timescale 1ns/100ps
`default_nettype none
`include "ascl_cfg.svh"
module ascl_top #(
    parameter int ADDR_W = 8
) (
    input  wire logic                 aclk,          // Clock, 50 MHz
    input  wire logic                 aresetn,       // Sync reset, low
    input  wire logic [ADDR_W-1:0]    awaddr,        // Write address
    input  wire logic                 awvalid,       // Write address valid
    output var  logic                 awready,       // Write address ready
    input  wire logic [31:0]          wdata,         // Write data
    input  wire logic [3:0]           wstrb,         // Write strobes
    input  wire logic                 wvalid,        // Write data valid
    output var  logic                 wready,        // Write data ready
    output var  logic [1:0]           bresp,         // Write response
    output var  logic                 bvalid,        // Write response valid
    input  wire logic                 bready,        // Write response ready
    input  wire logic [ADDR_W-1:0]    araddr,        // Read address
    input  wire logic                 arvalid,       // Read address valid
    output var  logic                 arready,       // Read address ready
    output var  logic [31:0]          rdata,         // Read data
    output var  logic [1:0]           rresp,         // Read response
    output var  logic                 rvalid,        // Read data valid
    input  wire logic                 rready,        // Read data ready
    input  wire logic                 hw_trigger,    // Hardware trigger pin
    output var  logic                 conv_start,    // Start pulse to core
    output var  logic                 core_power,    // Core powered
    output var  ascl_pkg::ascl_chan_t core_chan,     // Input index to core
    output var  logic                 core_ext_en,   // Analog input switch
    output var  logic                 core_ref_hi,   // High reference switch
    output var  logic                 core_ref_lo,   // Low reference switch
    input  wire logic                 core_done,     // Core finished, pulse
    input  wire ascl_pkg::ascl_res_t  core_result,   // Core result
    output var  logic                 irq            // Interrupt, high level
);
    import ascl_pkg::*;

    ascl_state_t       state_q;
    ascl_state_t       state_d;
    logic              done_q;
    logic              ie_q;
    logic              cont_q;
    ascl_chan_t        chan_q;
    logic              hwt_q;
    logic              cmp_en_q;
    logic              cmp_gt_q;
    ascl_res_t         cmp_q;
    ascl_res_t         res_q;
    logic [`ASCL_IRQ_W-1:0] ists_q;
    logic [`ASCL_IRQ_W-1:0] ists_d;
    logic [`ASCL_IRQ_W-1:0] ien_q;
    logic [ADDR_W-1:0] aw_q;
    logic [31:0]       wd_q;
    logic [3:0]        ws_q;
    logic              wr_go;
    logic              wr_b0;
    logic              sc_wr;
    logic              res_rd;
    logic              trig;
    logic              done_evt;
    logic              cmp_true;
    logic              done_set;
    logic              start_now;
    logic              ch_off_now;
    logic              dec_ext;
    logic              dec_hi;
    logic              dec_lo;
    logic              dec_off;
    logic [31:0]       rd_mux;
    logic              rd_ok;

    ascl_sync3 u_sync (
        .aclk    (aclk),
        .aresetn (aresetn),
        .pin     (hw_trigger),
        .rise    (trig)
    );

    ascl_chan_decode u_dec (
        .code   (chan_q),
        .ext_en (dec_ext),
        .ref_hi (dec_hi),
        .ref_lo (dec_lo),
        .off    (dec_off)
    );

    // Write channel: address and data taken in either order
    assign wr_go = !awready && !wready && !bvalid;
    assign wr_b0 = wr_go && ws_q[0];
    assign sc_wr = wr_b0 && (aw_q == `ASCL_OFF_SC);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready <= 1'b1;
            wready  <= 1'b1;
            bvalid  <= 1'b0;
            bresp   <= `ASCL_RESP_OKAY;
            aw_q    <= '0;
            wd_q    <= '0;
            ws_q    <= '0;
        end else begin
            if (awvalid && awready) begin
                awready <= 1'b0;
                aw_q    <= awaddr;
            end
            if (wvalid && wready) begin
                wready <= 1'b0;
                wd_q   <= wdata;
                ws_q   <= wstrb;
            end
            if (wr_go) begin
                bvalid <= 1'b1;
                bresp  <= (aw_q > `ASCL_OFF_IEN || aw_q[1:0] != 2'h0) ?
                          `ASCL_RESP_SLVERR : `ASCL_RESP_OKAY;
            end
            if (bvalid && bready) begin
                bvalid  <= 1'b0;
                awready <= 1'b1;
                wready  <= 1'b1;
            end
        end
    end

    // Read channel
    assign res_rd = arvalid && arready && (araddr == `ASCL_OFF_RES);

    always_comb begin
        rd_mux = '0;
        rd_ok  = 1'b1;
        case (araddr)
            `ASCL_OFF_SC:   rd_mux = {24'h0000_00, done_q, ie_q, cont_q, chan_q};
            `ASCL_OFF_CFG:  rd_mux = {29'h0000_0000, cmp_gt_q, cmp_en_q, hwt_q};
            `ASCL_OFF_CMP:  rd_mux = {20'h0_0000, cmp_q};
            `ASCL_OFF_RES:  rd_mux = {20'h0_0000, res_q};                 // see [RULE12]
            `ASCL_OFF_ISTS: rd_mux = {30'h0000_0000, ists_q};
            `ASCL_OFF_ICLR: rd_mux = '0;
            `ASCL_OFF_IEN:  rd_mux = {30'h0000_0000, ien_q};
            default:        rd_ok  = 1'b0;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready <= 1'b1;
            rvalid  <= 1'b0;
            rdata   <= '0;
            rresp   <= `ASCL_RESP_OKAY;
        end else begin
            if (arvalid && arready) begin
                arready <= 1'b0;
                rvalid  <= 1'b1;
                rdata   <= rd_mux;
                rresp   <= rd_ok ? `ASCL_RESP_OKAY : `ASCL_RESP_SLVERR;
            end
            if (rvalid && rready) begin
                rvalid  <= 1'b0;
                arready <= 1'b1;
            end
        end
    end

    // Software-written configuration
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ie_q     <= 1'b0;
            cont_q   <= 1'b0;
            chan_q   <= `ASCL_CH_OFF;
            hwt_q    <= 1'b0;
            cmp_en_q <= 1'b0;
            cmp_gt_q <= 1'b0;
            cmp_q    <= '0;
            ien_q    <= '0;
        end else begin
            if (sc_wr) begin
                ie_q   <= wd_q[`ASCL_SC_IE];
                cont_q <= wd_q[`ASCL_SC_CONT];
                chan_q <= wd_q[`ASCL_SC_CH_HI:0];
            end
            if (wr_b0 && aw_q == `ASCL_OFF_CFG) begin
                hwt_q    <= wd_q[`ASCL_CFG_HWT];                          // see [RULE12]
                cmp_en_q <= wd_q[`ASCL_CFG_CMPEN];
                cmp_gt_q <= wd_q[`ASCL_CFG_CMPGT];
            end
            if (wr_go && aw_q == `ASCL_OFF_CMP) begin
                if (ws_q[0]) begin
                    cmp_q[7:0] <= wd_q[7:0];
                end
                if (ws_q[1]) begin
                    cmp_q[11:8] <= wd_q[11:8];
                end
            end
            if (wr_b0 && aw_q == `ASCL_OFF_IEN) begin
                ien_q <= wd_q[`ASCL_IRQ_W-1:0];
            end
        end
    end

    // Conversion sequencing
    assign done_evt   = (state_q == st_conv) && core_done;
    assign ch_off_now = (wd_q[`ASCL_SC_CH_HI:0] == `ASCL_CH_OFF);

    always_comb begin
        start_now = 1'b0;
        if (sc_wr) begin
            start_now = !ch_off_now && !hwt_q;                            // see [RULE5] [RULE6] [RULE10]
        end else if (!dec_off) begin
            start_now = (trig && hwt_q && state_q == st_idle) ||          // see [RULE5] [RULE7]
                        (done_evt && cont_q);                             // see [RULE6] [RULE7]
        end
    end

    always_comb begin
        state_d = state_q;
        case (state_q)
            st_idle: begin
                if (start_now) begin
                    state_d = st_conv;
                end
            end
            st_conv: begin
                if (start_now) begin
                    state_d = st_conv;
                end else if (sc_wr || done_evt) begin
                    state_d = st_idle;                                    // see [RULE11] [RULE10]
                end
            end
            default: state_d = st_idle;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_q    <= st_idle;
            conv_start <= 1'b0;
            core_power <= 1'b0;
        end else begin
            state_q    <= state_d;
            conv_start <= start_now;
            core_power <= (state_d == st_conv);                           // see [RULE9] [RULE11]
        end
    end

    // Input switch drive, all open when the converter is off
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            core_chan   <= '0;
            core_ext_en <= 1'b0;
            core_ref_hi <= 1'b0;
            core_ref_lo <= 1'b0;
        end else begin
            core_chan   <= chan_q;                                        // see [RULE8]
            core_ext_en <= dec_ext;                                       // see [RULE9]
            core_ref_hi <= dec_hi;
            core_ref_lo <= dec_lo;
        end
    end

    // Completion flag and result
    assign cmp_true = cmp_gt_q ? (core_result >= cmp_q) : (core_result < cmp_q);
    assign done_set = done_evt && (!cmp_en_q || cmp_true);                // see [RULE1] [RULE2]

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            done_q <= 1'b0;
            res_q  <= '0;
        end else begin
            if (done_set) begin
                done_q <= 1'b1;
                res_q  <= core_result;
            end else if (sc_wr || res_rd) begin
                done_q <= 1'b0;                                           // see [RULE3]
            end
        end
    end

    // Interrupt status, set wins over clear
    always_comb begin
        ists_d = ists_q;
        if (wr_b0 && aw_q == `ASCL_OFF_ICLR) begin
            ists_d = ists_q & ~wd_q[`ASCL_IRQ_W-1:0];
        end
        ists_d[`ASCL_IRQ_DONE] = ists_d[`ASCL_IRQ_DONE] || (done_set && ie_q); // see [RULE4]
        ists_d[`ASCL_IRQ_END]  = ists_d[`ASCL_IRQ_END] || done_evt;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ists_q <= '0;
            irq    <= 1'b0;
        end else begin
            ists_q <= ists_d;
            irq    <= |(ists_d & ien_q);                                  // see [RULE4]
        end
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    property p_done_plain;
        done_evt && !cmp_en_q |=> done_q && res_q == $past(core_result);
    endproperty
    a_done_plain: assert property (p_done_plain) else $error("done not set"); // see [RULE1]

    property p_done_cmp;
        done_evt && cmp_en_q && !cmp_true && !done_q && !sc_wr |=> !done_q;
    endproperty
    a_done_cmp: assert property (p_done_cmp) else $error("done set on false compare"); // see [RULE2]

    property p_done_clr;
        (sc_wr || res_rd) && !done_set |=> !done_q;
    endproperty
    a_done_clr: assert property (p_done_clr) else $error("done not cleared"); // see [RULE3]

    property p_irq;
        done_set && ie_q && ien_q[`ASCL_IRQ_DONE] |=> irq [*2];
    endproperty
    a_irq: assert property (p_irq) else $error("irq missing"); // see [RULE4]

    property p_no_irq;
        !ie_q && !ists_q[`ASCL_IRQ_DONE] |=> !ists_q[`ASCL_IRQ_DONE];
    endproperty
    a_no_irq: assert property (p_no_irq) else $error("irq status set while disabled"); // see [RULE4]

    property p_sw_start;
        sc_wr && !hwt_q && !ch_off_now |=> conv_start ##1 core_power;
    endproperty
    a_sw_start: assert property (p_sw_start) else $error("write gave no start"); // see [RULE5]

    property p_single_end;
        done_evt && !cont_q && !sc_wr |=> !conv_start && !core_power;
    endproperty
    a_single_end: assert property (p_single_end) else $error("single mode kept running"); // see [RULE11]

    property p_cont;
        done_evt && cont_q && !dec_off && !sc_wr |=> conv_start && state_q == st_conv;
    endproperty
    a_cont: assert property (p_cont) else $error("continuous restart missing"); // see [RULE6]

    property p_hw;
        trig && hwt_q && state_q == st_idle && !dec_off && !sc_wr |=> conv_start;
    endproperty
    a_hw: assert property (p_hw) else $error("trigger gave no start"); // see [RULE7]

    property p_off;
        sc_wr && ch_off_now |=> !conv_start && !core_power ##1 !core_ext_en;
    endproperty
    a_off: assert property (p_off) else $error("off code did not stop"); // see [RULE10]

    property p_refh;
        chan_q == `ASCL_CH_REFH |=> core_ref_hi && !core_ext_en;
    endproperty
    a_refh: assert property (p_refh) else $error("high reference not chosen"); // see [RULE8]

    c_cont: cover property (done_evt && cont_q ##1 conv_start);
    c_hw:   cover property (trig && hwt_q ##1 conv_start);
    c_cmp:  cover property (done_evt && cmp_en_q && !cmp_true);
endmodule : ascl_top
`default_nettype wire

/* src/ascl_cfg.svh */
`ifndef ASCL_CFG_SVH
`define ASCL_CFG_SVH
// Register byte offsets
`define ASCL_OFF_SC      8'h00
`define ASCL_OFF_CFG     8'h04
`define ASCL_OFF_CMP     8'h08
`define ASCL_OFF_RES     8'h0c
`define ASCL_OFF_ISTS    8'h10
`define ASCL_OFF_ICLR    8'h14
`define ASCL_OFF_IEN     8'h18
// conversion_status_control fields
`define ASCL_SC_DONE     7
`define ASCL_SC_IE       6
`define ASCL_SC_CONT     5
`define ASCL_SC_CH_HI    4
// Config fields
`define ASCL_CFG_HWT     0
`define ASCL_CFG_CMPEN   1
`define ASCL_CFG_CMPGT   2
// Interrupt status bits
`define ASCL_IRQ_DONE    0
`define ASCL_IRQ_END     1
`define ASCL_IRQ_W       2
// Channel codes
`define ASCL_CH_EXT_LAST 5'h1b
`define ASCL_CH_RSVD     5'h1c
`define ASCL_CH_REFH     5'h1d
`define ASCL_CH_REFL     5'h1e
`define ASCL_CH_OFF      5'h1f
// Reset value and response codes
`define ASCL_SC_RST      8'h1f
`define ASCL_RESP_OKAY   2'h0
`define ASCL_RESP_SLVERR 2'h2
`endif

/* src/ascl_pkg.sv */
package ascl_pkg;
    typedef logic [4:0]  ascl_chan_t;
    typedef logic [11:0] ascl_res_t;
    typedef enum logic [1:0] {
        st_idle = 2'b01,
        st_conv = 2'b10
    } ascl_state_t;
endpackage : ascl_pkg

/* src/ascl_sync3.sv */
`timescale 1ns/100ps
`default_nettype none
module ascl_sync3 (
    input  wire logic aclk,     // Clock
    input  wire logic aresetn,  // Sync reset, low
    input  wire logic pin,      // Async input
    output var  logic rise      // One-cycle pulse on filtered rise
);
    logic s1_q;
    logic s2_q;
    logic s3_q;
    logic lvl_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
        end else begin
            s1_q <= pin;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // A change counts only once stages two and three agree
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            lvl_q <= 1'b0;
            rise  <= 1'b0;
        end else begin
            rise <= (s2_q == s3_q) && s3_q && !lvl_q;
            if (s2_q == s3_q) begin
                lvl_q <= s3_q;
            end
        end
    end
endmodule : ascl_sync3
`default_nettype wire

/* src/ascl_chan_decode.sv */
`timescale 1ns/100ps
`default_nettype none
`include "ascl_cfg.svh"
module ascl_chan_decode (
    input  wire ascl_pkg::ascl_chan_t code,    // Channel select code
    output var  logic                 ext_en,  // Analog input chosen
    output var  logic                 ref_hi,  // High reference chosen
    output var  logic                 ref_lo,  // Low reference chosen
    output var  logic                 off      // Converter switched off
);
    import ascl_pkg::*;

    always_comb begin
        ext_en = 1'b0;
        ref_hi = 1'b0;
        ref_lo = 1'b0;
        off    = 1'b0;
        if (code <= `ASCL_CH_EXT_LAST) begin
            ext_en = 1'b1;                        // see [RULE8]
        end else begin
            case (code)
                `ASCL_CH_REFH: ref_hi = 1'b1;     // see [RULE8]
                `ASCL_CH_REFL: ref_lo = 1'b1;     // see [RULE8]
                `ASCL_CH_OFF:  off    = 1'b1;     // see [RULE9]
                default:       off    = 1'b0;
            endcase
        end
    end
endmodule : ascl_chan_decode
`default_nettype wire

/* dv/ascl_core_model.sv */
`timescale 1ns/100ps
`default_nettype none
module ascl_core_model (
    input  wire logic                 aclk,        // Clock
    input  wire logic                 aresetn,     // Sync reset, low
    input  wire logic [7:0]           lat,         // Cycles per conversion
    input  wire logic                 conv_start,  // Start pulse
    input  wire logic                 core_power,  // Core powered
    input  wire ascl_pkg::ascl_chan_t core_chan,   // Channel index
    output var  logic                 core_done,   // Done pulse
    output var  ascl_pkg::ascl_res_t  core_result  // Result, valid with done
);
    import ascl_pkg::*;
    logic [7:0] cnt_q;
    always_ff @(posedge aclk) begin
        core_done <= 1'b0;
        // Result only holds during the done pulse
        core_result <= ~core_result;
        if (!aresetn) begin
            cnt_q       <= 8'h00;
            core_result <= 12'h000;
        end else if (conv_start) begin
            cnt_q <= lat;
        end else if (!core_power) begin
            cnt_q <= 8'h00;
        end else if (cnt_q == 8'h01) begin
            cnt_q       <= 8'h00;
            core_done   <= 1'b1;
            core_result <= 12'h5a0 ^ {7'h00, core_chan};
        end else if (cnt_q != 8'h00) begin
            cnt_q <= cnt_q - 8'h01;
        end
    end
endmodule : ascl_core_model
`default_nettype wire

/* dv/ascl_top_bench.sv */
`timescale 1ns/100ps
`default_nettype none
`include "ascl_cfg.svh"
module ascl_top_bench;
    import ascl_pkg::*;
    typedef struct packed {
        logic [4:0] chan;
        logic [2:0] sw;
        logic       done;
    } ascl_row_t;
    localparam ascl_row_t ROWS [8] = '{
        '{5'h00, 3'b100, 1'b1}, '{5'h0f, 3'b100, 1'b1}, '{5'h10, 3'b100, 1'b1},
        '{5'h1b, 3'b100, 1'b1}, '{5'h1c, 3'b000, 1'b1}, '{5'h1d, 3'b010, 1'b1},
        '{5'h1e, 3'b001, 1'b1}, '{5'h1f, 3'b000, 1'b0}};
    logic        aclk = 1'b0, aresetn = 1'b0, hw_trigger = 1'b0;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00, lat = 8'h03;
    logic [31:0] wdata = 32'h0000_0000, rd, rdata;
    logic [3:0]  wstrb = 4'hf;
    logic [1:0]  bresp, rresp, rsp;
    logic        awready, wready, bvalid, arready, rvalid, irq;
    logic        conv_start, core_power, core_ext_en, core_ref_hi, core_ref_lo, core_done;
    ascl_chan_t  core_chan;
    ascl_res_t   core_result;
    int          error_cnt = 0, check_count = 0, cyc = 0, starts = 0, n;

    ascl_top dut_u (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .hw_trigger(hw_trigger), .conv_start(conv_start), .core_power(core_power),
        .core_chan(core_chan), .core_ext_en(core_ext_en), .core_ref_hi(core_ref_hi),
        .core_ref_lo(core_ref_lo), .core_done(core_done), .core_result(core_result),
        .irq(irq));
    ascl_core_model model_u (.aclk(aclk), .aresetn(aresetn), .lat(lat),
        .conv_start(conv_start), .core_power(core_power), .core_chan(core_chan),
        .core_done(core_done), .core_result(core_result));

    always #10 aclk = ~aclk;
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (conv_start === 1'b1) starts <= starts + 1;
        if (cyc == 20000) begin
            error_cnt++;
            tally_and_finish();
        end
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic aw_ok, w_ok;
        aw_ok = 1'b0;
        w_ok  = 1'b0;
        @(posedge aclk);
        awaddr  <= a;
        wdata   <= d;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        while (!(aw_ok && w_ok)) begin
            @(posedge aclk);
            if (!aw_ok && awready === 1'b1) begin
                aw_ok = 1'b1;
                awvalid <= 1'b0;
            end
            if (!w_ok && wready === 1'b1) begin
                w_ok = 1'b1;
                wvalid <= 1'b0;
            end
        end
        do @(posedge aclk); while (bvalid !== 1'b1);
        rsp = bresp;
        bready <= 1'b0;
    endtask : wr

    task automatic rdr(input logic [7:0] a);
        @(posedge aclk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do @(posedge aclk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge aclk); while (rvalid !== 1'b1);
        rd = rdata;
        rsp = rresp;
        rready <= 1'b0;
    endtask : rdr

    task automatic wait_idle;
        for (int k = 0; k < 300 && core_power !== 1'b0; k++) @(posedge aclk);
        repeat (2) @(posedge aclk);
    endtask : wait_idle

    task automatic trig;
        @(posedge aclk);
        hw_trigger <= 1'b1;
        repeat (3) @(posedge aclk);
        hw_trigger <= 1'b0;
    endtask : trig

    task automatic tally_and_finish;
        $display("checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : tally_and_finish

    initial begin
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        rdr(`ASCL_OFF_SC);
        chk(rd, 32'h0000_001f);
        chk(32'(rsp), 32'(`ASCL_RESP_OKAY));
        rdr(`ASCL_OFF_CFG);
        chk(rd, 32'h0000_0000);
        chk(32'(irq), 32'h0);
        // Channel decode and single software conversions
        for (int i = 0; i < 8; i++) begin
            wr(`ASCL_OFF_SC, {27'h0, ROWS[i].chan});
            chk(32'(rsp), 32'(`ASCL_RESP_OKAY));
            // Switches follow the channel one edge after the write lands
            @(posedge aclk);
            chk(32'({core_ext_en, core_ref_hi, core_ref_lo}), 32'(ROWS[i].sw));
            chk(32'(core_power), 32'(ROWS[i].done));
            wait_idle();
            chk(32'(core_power), 32'h0);
            rdr(`ASCL_OFF_SC);
            chk(32'(rd[7]), 32'(ROWS[i].done));
            if (ROWS[i].done) begin
                rdr(`ASCL_OFF_RES);
                chk(rd, 32'(12'h5a0 ^ {7'h00, ROWS[i].chan}));
                rdr(`ASCL_OFF_SC);
                chk(32'(rd[7]), 32'h0);
            end
        end
        // Interrupt raise, write-clear of the flag, status clear, masked case
        wr(`ASCL_OFF_IEN, 32'h0000_0001);
        wr(`ASCL_OFF_SC, 32'h0000_0043);
        wait_idle();
        chk(32'(irq), 32'h1);
        lat <= 8'h28;
        wr(`ASCL_OFF_SC, 32'h0000_0043);
        rdr(`ASCL_OFF_SC);
        chk(32'(rd[7]), 32'h0);
        wr(`ASCL_OFF_ICLR, 32'h0000_0003);
        chk(32'(irq), 32'h0);
        wait_idle();
        chk(32'(irq), 32'h1);
        wr(`ASCL_OFF_ICLR, 32'h0000_0003);
        lat <= 8'h03;
        wr(`ASCL_OFF_SC, 32'h0000_0003);
        wait_idle();
        rdr(`ASCL_OFF_ISTS);
        chk(32'(rd[0]), 32'h0);
        chk(32'(irq), 32'h0);
        rdr(8'h20);
        chk(32'(rsp), 32'(`ASCL_RESP_SLVERR));
        chk(rd, 32'h0000_0000);
        wr(8'h20, 32'h0000_0000);
        chk(32'(rsp), 32'(`ASCL_RESP_SLVERR));
        // Compare gating, false then equal boundary
        wr(`ASCL_OFF_CFG, 32'h0000_0006);
        wr(`ASCL_OFF_CMP, 32'h0000_0fff);
        wr(`ASCL_OFF_SC, 32'h0000_0003);
        wait_idle();
        rdr(`ASCL_OFF_SC);
        chk(32'(rd[7]), 32'h0);
        wr(`ASCL_OFF_CMP, 32'h0000_05a3);
        wr(`ASCL_OFF_SC, 32'h0000_0003);
        wait_idle();
        rdr(`ASCL_OFF_SC);
        chk(32'(rd[7]), 32'h1);
        wr(`ASCL_OFF_CFG, 32'h0000_0000);
        // Continuous software mode, then stop by the off code
        n = starts;
        wr(`ASCL_OFF_SC, 32'h0000_0022);
        repeat (40) @(posedge aclk);
        chk(32'(starts - n >= 3), 32'h1);
        wr(`ASCL_OFF_SC, 32'h0000_003f);
        n = starts;
        repeat (40) @(posedge aclk);
        chk(32'(starts - n), 32'h0);
        chk(32'(core_power), 32'h0);
        rdr(`ASCL_OFF_SC);
        chk(32'(rd[7]), 32'h0);
        // Hardware trigger, single then continuous
        wr(`ASCL_OFF_CFG, 32'h0000_0001);
        n = starts;
        wr(`ASCL_OFF_SC, 32'h0000_0004);
        repeat (20) @(posedge aclk);
        chk(32'(starts - n), 32'h0);
        trig();
        repeat (30) @(posedge aclk);
        chk(32'(starts - n), 32'h1);
        wr(`ASCL_OFF_SC, 32'h0000_0024);
        n = starts;
        repeat (20) @(posedge aclk);
        chk(32'(starts - n), 32'h0);
        trig();
        repeat (40) @(posedge aclk);
        chk(32'(starts - n >= 3), 32'h1);
        wr(`ASCL_OFF_SC, 32'h0000_001f);
        tally_and_finish();
    end
endmodule : ascl_top_bench
`default_nettype wire
